// *** hw/cpg_counter.sv ***
// counter with edge separation capture, pulse generation and square wave divider
`timescale 1ns/1ns

// Function
// - count source edges gate to aux, save
// - next gate edge starts new interval
// - each saved count offered to DMA
// - single pulse: delay then width edges
// - source active edge rising or falling
// - gate trigger starts delay, then ignored
// - retrigger ignored while running, then rewait
// - train: delay, then high/low phases
// - train starts on arm or gate trigger
// - gate as pause halts train
// - square wave divides by 1 to 16
// - square wave timebase 10 MHz or 100 kHz
// - odd divisor above 1 low (D+1)/2, high (D-1)/2
// - gate edge pulse, delay grows by increment
// - delay increment 0 to 255
// - gate ignored while busy, repeat until disarm
// - terminal count when counter reaches zero
// - output pulses or toggles, selectable polarity
// - counter functions start only after software or hardware arm; square wave runs on its enable alone
module cpg_counter #(
	parameter int CNT_W = 32 // counter width
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             clk_en,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             source_in,
	input  wire logic             gate_in,
	input  wire logic             aux_in,
	input  wire logic             hardware_arm_input,
	input  wire logic             tb_10mhz_in,
	input  wire logic             tb_100khz_in,
	output logic                  internal_out,
	output logic                  terminal_count_flag,
	output logic                  square_wave_out,
	output logic                  dma_valid,
	output logic      [CNT_W-1:0] dma_data,
	input  wire logic             dma_ready
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// active edge of a sampled input, falling when fall is set
	function automatic logic edge_hit(input logic cur, input logic prev, input logic fall);
		edge_hit = fall ? (prev & ~cur) : (~prev & cur);
	endfunction

	// width of a phase, zero treated as one edge
	function automatic logic [CNT_W-1:0] min_one(input logic [CNT_W-1:0] v);
		min_one = (v == '0) ? CNT_W'(1) : v;
	endfunction

	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] WIDTH_INIT = CNT_W'(cpg_pkg::WIDTH_RST); // default width
	logic [cpg_pkg::CTRL_W-1:0] ctrl_r;      // control bits
	logic [CNT_W-1:0]           delay_r;     // programmed delay
	logic [CNT_W-1:0]           high_r;      // programmed high width
	logic [CNT_W-1:0]           low_r;       // programmed low width
	logic [cpg_pkg::INCR_W-1:0] incr_r;      // delay increment
	logic [cpg_pkg::FREQ_W-1:0] freq_r;      // divider control
	logic [CNT_W-1:0]           cnt_r;       // working counter
	logic [CNT_W-1:0]           cur_delay_r; // delay for step mode
	logic [CNT_W-1:0]           save_r;      // latched count
	logic                       ovf_r;       // save overwritten before taken
	logic                       lvl_r;       // phase level of output
	logic                       tc_r;        // terminal count pulse
	logic                       src_q;       // previous source sample
	logic                       gate_q;      // previous gate sample
	logic                       aux_q;       // previous aux sample
	logic                       arm_q;       // previous hardware arm sample
	logic                       tbf_q;       // previous fast timebase sample
	logic                       tbs_q;       // previous slow timebase sample
	logic [3:0]                 fcnt_r;      // divider position
	logic                       sq_r;        // square wave level
	cpg_pkg::cpg_state_t        state_r;     // function state

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	cpg_pkg::cpg_mode_t mode;       // selected function
	logic               wr_en;      // register write this cycle
	logic               cmd_wr;     // command strobe write
	logic               sw_arm;     // software arm
	logic               pin_arm;    // hardware arm edge
	logic               disarm;     // software disarm
	logic               src_hit;    // active source edge
	logic               gate_hit;   // active gate edge
	logic               aux_hit;    // active aux edge
	logic               paused;     // pause gate active
	logic               phase_end;  // counter reaches zero
	logic               latch;      // edge separation capture
	logic               single;     // function ends after one pulse

	assign mode     = cpg_cpg_mode(ctrl_r[cpg_pkg::CTRL_MODE_LSB +: 3]);
	assign wr_en    = clk_en & psel & penable & pwrite;
	assign cmd_wr   = wr_en & (paddr == cpg_pkg::OFS_CMD);
	assign sw_arm   = cmd_wr & pwdata[cpg_pkg::CMD_ARM];
	assign disarm   = cmd_wr & pwdata[cpg_pkg::CMD_DISARM];
	assign pin_arm  = ctrl_r[cpg_pkg::CTRL_HWARM_EN] & ~arm_q & hardware_arm_input;
	assign src_hit  = edge_hit(source_in, src_q, ctrl_r[cpg_pkg::CTRL_SRC_FALL]);
	assign gate_hit = edge_hit(gate_in, gate_q, ctrl_r[cpg_pkg::CTRL_GATE_FALL]);
	assign aux_hit  = edge_hit(aux_in, aux_q, ctrl_r[cpg_pkg::CTRL_AUX_FALL]);
	assign paused   = (mode == cpg_pkg::MODE_TRAIN) & ctrl_r[cpg_pkg::CTRL_PAUSE_EN]
	                & ~ctrl_r[cpg_pkg::CTRL_START_EN]
	                & (gate_in ^ ctrl_r[cpg_pkg::CTRL_GATE_FALL]);
	assign phase_end = src_hit & ~paused & (cnt_r == CNT_W'(1))
	                 & ((state_r == cpg_pkg::ST_DELAY) | (state_r == cpg_pkg::ST_HIGH)
	                 | (state_r == cpg_pkg::ST_LOW));
	assign latch    = (state_r == cpg_pkg::ST_MEASURE) & aux_hit;
	assign single   = (mode == cpg_pkg::MODE_SINGLE) | (mode == cpg_pkg::MODE_SINGLE_TRIG);

	// mode field to enum
	function automatic cpg_pkg::cpg_mode_t cpg_cpg_mode(input logic [2:0] v);
		cpg_cpg_mode = cpg_pkg::cpg_mode_t'(v);
	endfunction

	// ------------------------------------------------------------
	// input sampling
	// ------------------------------------------------------------

	// previous samples for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q  <= 1'b0;
			gate_q <= 1'b0;
			aux_q  <= 1'b0;
			arm_q  <= 1'b0;
			tbf_q  <= 1'b0;
			tbs_q  <= 1'b0;
		end else if (clk_en) begin
			src_q  <= source_in;
			gate_q <= gate_in;
			aux_q  <= aux_in;
			arm_q  <= hardware_arm_input;
			tbf_q  <= tb_10mhz_in;
			tbs_q  <= tb_100khz_in;
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r  <= cpg_pkg::CTRL_RST;
			delay_r <= '0;
			high_r  <= WIDTH_INIT;
			low_r   <= WIDTH_INIT;
			incr_r  <= '0;
			freq_r  <= cpg_pkg::FREQ_RST;
		end else if (wr_en) begin
			case (paddr)
				cpg_pkg::OFS_CTRL:  ctrl_r  <= pwdata[cpg_pkg::CTRL_W-1:0];
				cpg_pkg::OFS_DELAY: delay_r <= pwdata[CNT_W-1:0];
				cpg_pkg::OFS_HIGH:  high_r  <= pwdata[CNT_W-1:0];
				cpg_pkg::OFS_LOW:   low_r   <= pwdata[CNT_W-1:0];
				cpg_pkg::OFS_INCR:  incr_r  <= pwdata[cpg_pkg::INCR_W-1:0];
				cpg_pkg::OFS_FREQ:  freq_r  <= pwdata[cpg_pkg::FREQ_W-1:0];
				default:            ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// function state machine
	// ------------------------------------------------------------

	// state, counter and phase level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r     <= cpg_pkg::ST_IDLE;
			cnt_r       <= '0;
			cur_delay_r <= '0;
			lvl_r       <= 1'b0;
		end else if (clk_en) begin
			if (disarm) begin
				// disarm wins over everything
				state_r <= cpg_pkg::ST_IDLE;
				lvl_r   <= 1'b0;
			end else begin
				case (state_r)
					cpg_pkg::ST_IDLE: begin
						if (sw_arm | pin_arm) begin
							lvl_r       <= 1'b0;
							cur_delay_r <= delay_r;
							cnt_r       <= min_one(delay_r);
							if ((mode == cpg_pkg::MODE_SINGLE) | ((mode == cpg_pkg::MODE_TRAIN)
							    & ~ctrl_r[cpg_pkg::CTRL_START_EN]))
								state_r <= cpg_pkg::ST_DELAY;
							else
								state_r <= cpg_pkg::ST_WAIT;
						end
					end
					cpg_pkg::ST_WAIT: begin
						if (gate_hit & (mode == cpg_pkg::MODE_EDGE_SEP)) begin
							cnt_r   <= '0;
							state_r <= cpg_pkg::ST_MEASURE;
						end else if (gate_hit) begin
							cnt_r   <= min_one(cur_delay_r);
							state_r <= cpg_pkg::ST_DELAY;
						end
					end
					cpg_pkg::ST_MEASURE: begin
						// aux after capture waits for gate
						if (latch)
							state_r <= cpg_pkg::ST_WAIT;
						else if (src_hit)
							cnt_r <= cnt_r + CNT_W'(1);
					end
					cpg_pkg::ST_DELAY: begin
						if (phase_end) begin
							cnt_r   <= min_one(high_r);
							lvl_r   <= 1'b1;
							state_r <= cpg_pkg::ST_HIGH;
						end else if (src_hit & ~paused)
							cnt_r <= cnt_r - CNT_W'(1);
					end
					cpg_pkg::ST_HIGH: begin
						if (phase_end) begin
							lvl_r <= 1'b0;
							if (mode == cpg_pkg::MODE_TRAIN) begin
								cnt_r   <= min_one(low_r);
								state_r <= cpg_pkg::ST_LOW;
							end else if (single)
								state_r <= cpg_pkg::ST_DONE;
							else begin
								if (mode == cpg_pkg::MODE_STEP)
									cur_delay_r <= cur_delay_r + CNT_W'(incr_r);
								state_r <= cpg_pkg::ST_WAIT;
							end
						end else if (src_hit & ~paused)
							cnt_r <= cnt_r - CNT_W'(1);
					end
					cpg_pkg::ST_LOW: begin
						if (phase_end) begin
							cnt_r   <= min_one(high_r);
							lvl_r   <= 1'b1;
							state_r <= cpg_pkg::ST_HIGH;
						end else if (src_hit & ~paused)
							cnt_r <= cnt_r - CNT_W'(1);
					end
					cpg_pkg::ST_DONE: ;
					default: state_r <= cpg_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// terminal count and internal output
	// ------------------------------------------------------------

	// one cycle terminal count pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tc_r <= 1'b0;
		else if (clk_en)
			tc_r <= phase_end & ~disarm;
	end

	assign terminal_count_flag = tc_r;
	assign internal_out = ctrl_r[cpg_pkg::CTRL_OUT_INV]
	                    ^ (ctrl_r[cpg_pkg::CTRL_TOGGLE] ? lvl_r : tc_r);

	// ------------------------------------------------------------
	// save register and dma handshake
	// ------------------------------------------------------------

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			save_r    <= '0;
			dma_valid <= 1'b0;
			ovf_r     <= 1'b0;
		end else if (clk_en) begin
			if (latch) begin
				save_r    <= src_hit ? cnt_r + CNT_W'(1) : cnt_r;
				dma_valid <= 1'b1;
			end else if (dma_ready)
				dma_valid <= 1'b0;
			// overrun set wins over clear
			if (latch & dma_valid & ~dma_ready)
				ovf_r <= 1'b1;
			else if (cmd_wr & pwdata[cpg_pkg::CMD_CLROVF])
				ovf_r <= 1'b0;
		end
	end

	assign dma_data = save_r;

	// ------------------------------------------------------------
	// square wave divider
	// ------------------------------------------------------------
	logic       tb_tick;  // selected timebase edge
	logic [4:0] div_d;    // divisor 1..16
	logic [4:0] low_len;  // low part in ticks
	logic [3:0] fcnt_nxt; // next divider position

	assign tb_tick  = freq_r[cpg_pkg::FREQ_TB_SLOW] ? (~tbs_q & tb_100khz_in) : (~tbf_q & tb_10mhz_in);
	assign div_d    = {1'b0, freq_r[cpg_pkg::FREQ_DIV_LSB +: 4]} + 5'h01;
	assign low_len  = (div_d + 5'h01) >> 1;
	assign fcnt_nxt = (5'(fcnt_r) == div_d - 5'h01) ? 4'h0 : fcnt_r + 4'h1;

	// divider count and level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fcnt_r <= 4'h0;
			sq_r   <= 1'b0;
		end else if (clk_en) begin
			if (!freq_r[cpg_pkg::FREQ_EN]) begin
				fcnt_r <= 4'h0;
				sq_r   <= 1'b0;
			end else if (tb_tick) begin
				fcnt_r <= fcnt_nxt;
				if (div_d == 5'h01)
					sq_r <= ~sq_r;
				else
					sq_r <= (5'(fcnt_nxt) >= low_len);
			end
		end
	end

	assign square_wave_out = sq_r;

	// ------------------------------------------------------------
	// apb read side
	// ------------------------------------------------------------

	// read mux, unmapped returns error
	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		case (paddr)
			cpg_pkg::OFS_CTRL:   prdata[cpg_pkg::CTRL_W-1:0] = ctrl_r;
			cpg_pkg::OFS_CMD:    ;
			cpg_pkg::OFS_DELAY:  prdata[CNT_W-1:0] = delay_r;
			cpg_pkg::OFS_HIGH:   prdata[CNT_W-1:0] = high_r;
			cpg_pkg::OFS_LOW:    prdata[CNT_W-1:0] = low_r;
			cpg_pkg::OFS_INCR:   prdata[cpg_pkg::INCR_W-1:0] = incr_r;
			cpg_pkg::OFS_FREQ:   prdata[cpg_pkg::FREQ_W-1:0] = freq_r;
			cpg_pkg::OFS_STATUS: prdata[10:0] = {ovf_r, dma_valid, tc_r, lvl_r, 7'(state_r)};
			cpg_pkg::OFS_COUNT:  prdata[CNT_W-1:0] = cnt_r;
			cpg_pkg::OFS_SAVE:   prdata[CNT_W-1:0] = save_r;
			default:             pslverr = psel & penable;
		endcase
	end

	// stalls the bus while frozen
	assign pready = clk_en;

endmodule

// *** hw/cpg_pkg.sv ***
// shared constants and types for the counter and pulse generation block
package cpg_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00; // mode and polarity control
	localparam logic [7:0] OFS_CMD    = 8'h04; // arm, disarm, clear strobes
	localparam logic [7:0] OFS_DELAY  = 8'h08; // initial delay in source edges
	localparam logic [7:0] OFS_HIGH   = 8'h0C; // high phase width
	localparam logic [7:0] OFS_LOW    = 8'h10; // low phase width
	localparam logic [7:0] OFS_INCR   = 8'h14; // delay increment per trigger
	localparam logic [7:0] OFS_FREQ   = 8'h18; // square wave divider control
	localparam logic [7:0] OFS_STATUS = 8'h1C; // live state
	localparam logic [7:0] OFS_COUNT  = 8'h20; // live counter value
	localparam logic [7:0] OFS_SAVE   = 8'h24; // last latched count

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CTRL_MODE_LSB  = 0;  // three bit mode
	localparam int CTRL_SRC_FALL  = 3;  // source active edge falling
	localparam int CTRL_GATE_FALL = 4;  // gate active edge falling
	localparam int CTRL_AUX_FALL  = 5;  // aux active edge falling
	localparam int CTRL_START_EN  = 6;  // train waits for gate trigger
	localparam int CTRL_PAUSE_EN  = 7;  // gate acts as pause
	localparam int CTRL_TOGGLE    = 8;  // output toggles on terminal count
	localparam int CTRL_OUT_INV   = 9;  // invert internal output
	localparam int CTRL_HWARM_EN  = 10; // arm on hardware arm edge
	localparam int CTRL_W         = 11; // implemented control bits
	localparam logic [10:0] CTRL_RST = 11'h100; // toggle output by default

	// command strobe bits
	localparam int CMD_ARM    = 0;
	localparam int CMD_DISARM = 1;
	localparam int CMD_CLROVF = 2;

	// frequency control fields
	localparam int FREQ_DIV_LSB = 0; // divisor minus one, 4 bits
	localparam int FREQ_TB_SLOW = 4; // select slow timebase
	localparam int FREQ_EN      = 5; // divider running
	localparam int FREQ_W       = 6;
	localparam logic [5:0] FREQ_RST = 6'h00;

	// width resets
	localparam logic [31:0] WIDTH_RST = 32'h0000_0001;
	localparam int          INCR_W    = 8; // increment range 0..255

	// ------------------------------------------------------------
	// modes and states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_EDGE_SEP    = 3'h0, // buffered two signal edge separation
		MODE_SINGLE      = 3'h1, // single pulse from arming
		MODE_SINGLE_TRIG = 3'h2, // single pulse from gate trigger
		MODE_RETRIG      = 3'h3, // retriggerable pulse
		MODE_TRAIN       = 3'h4, // continuous pulse train
		MODE_STEP        = 3'h5  // incrementing delay pulses
	} cpg_mode_t;

	typedef enum logic [6:0] {
		ST_IDLE    = 7'h01, // disarmed
		ST_WAIT    = 7'h02, // armed, waiting for gate edge
		ST_DELAY   = 7'h04, // counting initial delay
		ST_HIGH    = 7'h08, // output high phase
		ST_LOW     = 7'h10, // output low phase
		ST_MEASURE = 7'h20, // counting between gate and aux
		ST_DONE    = 7'h40  // single function finished
	} cpg_state_t;

endpackage

// *** bench/cpg_counter_properties.sv ***
// port assertions for the counter and pulse block
`timescale 1ns/1ns
module cpg_counter_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        aux_in,
	input wire logic        internal_out,
	input wire logic        terminal_count_flag,
	input wire logic        square_wave_out,
	input wire logic        dma_valid,
	input wire logic        dma_ready
);
	// ------------------------------------------------------------
	// checks, all in the pclk domain
	// ------------------------------------------------------------
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ready_tracks_en: assert property (pready == clk_en)
		else $error("pready differs from clk_en");
	a_err_in_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	a_err_on_hole: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
		else $error("no pslverr on unmapped address");
	a_ok_on_reg: assert property (psel && penable && paddr <= 8'h24 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("pslverr on mapped address");
	a_cmd_reads_zero: assert property (psel && penable && !pwrite && paddr == cpg_pkg::OFS_CMD |-> prdata == 32'h0)
		else $error("command register read not zero");
	a_hole_reads_zero: assert property (psel && penable && !pwrite && paddr > 8'h24 |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_dma_holds: assert property (dma_valid && !dma_ready |=> dma_valid)
		else $error("saved count dropped before taken");
	a_dma_after_aux: assert property ($rose(dma_valid) |-> $past(aux_in) != $past(aux_in, 2))
		else $error("saved count without aux edge");
	a_tc_one_pulse: assert property (terminal_count_flag |=> !terminal_count_flag)
		else $error("terminal count longer than one cycle");
	a_freeze_outputs: assert property (!clk_en |=> $stable(internal_out) && $stable(square_wave_out)
		&& $stable(dma_valid))
		else $error("outputs moved while clock enable low");
endmodule

bind cpg_counter cpg_counter_properties cpg_counter_properties_inst (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .aux_in(aux_in), .internal_out(internal_out),
	.terminal_count_flag(terminal_count_flag), .square_wave_out(square_wave_out),
	.dma_valid(dma_valid), .dma_ready(dma_ready));

// *** bench/cpg_sig_src.sv ***
// partner model: source signal and the two timebases
`timescale 1ns/1ns
module cpg_sig_src #(
	parameter int SRC_HALF = 3 // source half period in pclk cycles
) (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      source_in,
	output logic      tb_10mhz_in,
	output logic      tb_100khz_in
);
	int src_cnt; // source half period count
	int tb_cnt;  // timebase phase count

	// free running source, idle low in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_cnt   <= 0;
			source_in <= 1'b0;
		end else begin
			src_cnt <= (src_cnt == SRC_HALF - 1) ? 0 : src_cnt + 1;
			if (src_cnt == SRC_HALF - 1) begin
				source_in <= ~source_in;
			end
		end
	end

	// 10 MHz and 100 kHz timebases from the 100 MHz clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tb_cnt       <= 0;
			tb_10mhz_in  <= 1'b0;
			tb_100khz_in <= 1'b0;
		end else begin
			tb_cnt       <= (tb_cnt == 999) ? 0 : tb_cnt + 1;
			tb_10mhz_in  <= (tb_cnt % 10) < 5;
			tb_100khz_in <= tb_cnt < 500;
		end
	end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the counter and pulse block
`timescale 1ns/1ns
module testbench;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, dma_data, q;
	logic        source_in, gate_in, aux_in, hardware_arm_input, tb_10mhz_in, tb_100khz_in;
	logic        internal_out, terminal_count_flag, square_wave_out, dma_valid, dma_ready;
	logic        use_fall, last_err, src_q, gate_q, aux_q; // bench state
	int          error_cnt, cmp_count, cyc, nedge, fedge, snap_g, snap_a, base, eb, e, b, x, tn;
	int          dv[5] = '{1, 4, 5, 16, 1}; // square wave divisors

	cpg_counter cpg_counter_inst (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .source_in(source_in), .gate_in(gate_in), .aux_in(aux_in),
		.hardware_arm_input(hardware_arm_input), .tb_10mhz_in(tb_10mhz_in),
		.tb_100khz_in(tb_100khz_in), .internal_out(internal_out),
		.terminal_count_flag(terminal_count_flag), .square_wave_out(square_wave_out),
		.dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready));
	cpg_sig_src cpg_sig_src_inst (.pclk(pclk), .presetn(presetn), .source_in(source_in),
		.tb_10mhz_in(tb_10mhz_in), .tb_100khz_in(tb_100khz_in));

	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	// edge counters in step with the block's own edge detection
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		src_q <= source_in;
		gate_q <= gate_in;
		aux_q <= aux_in;
		if (source_in && !src_q) begin
			nedge <= nedge + 1;
		end
		if (!source_in && src_q) begin
			fedge <= fedge + 1;
		end
		if (gate_in && !gate_q) begin
			snap_g <= nedge + int'(source_in && !src_q);
		end
		if (aux_in && !aux_q) begin
			snap_a <= nedge + int'(source_in && !src_q);
		end
		if (cyc == 60000) begin
			error_cnt++;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// wait for an output level, return active edges seen
	task automatic wait_out(input logic v, output int c);
		do begin
			@(posedge pclk);
			#1;
		end while (internal_out !== v);
		c = use_fall ? fedge : nedge;
	endtask

	task automatic run_pulse(input int d, input int h);
		int e1;
		wait_out(1'b1, e1);
		chk(32'(e1 - base), 32'(d));
		wait_out(1'b0, eb);
		chk(32'(eb - e1), 32'(h));
	endtask

	task automatic trig();
		@(posedge pclk);
		gate_in <= 1'b1;
		@(posedge pclk);
		#1;
		base = nedge;
		@(posedge pclk);
		gate_in <= 1'b0;
	endtask

	task automatic aux_pulse();
		@(posedge pclk);
		aux_in <= 1'b1;
		@(posedge pclk);
		@(posedge pclk);
		aux_in <= 1'b0;
	endtask

	task automatic cfg(input logic [31:0] c, input int d, input int h, input int l);
		wr(cpg_pkg::OFS_DELAY, 32'(d));
		wr(cpg_pkg::OFS_HIGH, 32'(h));
		wr(cpg_pkg::OFS_LOW, 32'(l));
		wr(cpg_pkg::OFS_CTRL, c);
	endtask

	task automatic arm();
		wr(cpg_pkg::OFS_CMD, 32'h1);
		#1;
		base = use_fall ? fedge : nedge;
	endtask

	// triggered pulses, a second gate edge lands inside each delay
	task automatic seq(input logic [31:0] c, input int d, input int h, input int inc, input int n);
		cfg(c, d, h, 1);
		arm();
		for (int i = 0; i < n; i++) begin
			trig();
			b = base;
			trig();
			base = b;
			run_pulse(d + inc * i, h);
		end
		wr(cpg_pkg::OFS_CMD, 32'h2);
	endtask

	task automatic wsq(input logic v, output int c);
		c = 0;
		do begin
			@(posedge pclk);
			#1;
			c++;
		end while (square_wave_out !== v);
	endtask

	task automatic tdone();
		tn++;
		$display("test %0d ended", tn);
	endtask

	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, gate_in, aux_in, hardware_arm_input, dma_ready} = 7'h00;
		{use_fall, src_q, gate_q, aux_q} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		clk_en = 1'b1;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(cpg_pkg::OFS_CTRL, 32'h100);
		rd(cpg_pkg::OFS_HIGH, 32'h1);
		rd(cpg_pkg::OFS_LOW, 32'h1);
		rd(cpg_pkg::OFS_FREQ, 32'h0);
		rd(cpg_pkg::OFS_CMD, 32'h0);
		rd(8'h40, 32'h0);
		chk(last_err, 1'b1);
		wr(cpg_pkg::OFS_INCR, 32'h1FF);
		rd(cpg_pkg::OFS_INCR, 32'hFF);
		tdone();
		cfg(32'h101, 4, 3, 1);
		arm();
		run_pulse(4, 3);
		rd(cpg_pkg::OFS_STATUS, 32'h40);
		wr(cpg_pkg::OFS_CMD, 32'h2);
		tdone();
		use_fall = 1'b1;
		cfg(32'h509, 2, 2, 1);
		rd(cpg_pkg::OFS_STATUS, 32'h1);
		@(posedge pclk);
		hardware_arm_input <= 1'b1;
		@(posedge pclk);
		#1;
		base = fedge;
		run_pulse(2, 2);
		@(posedge pclk);
		hardware_arm_input <= 1'b0;
		use_fall = 1'b0;
		wr(cpg_pkg::OFS_CMD, 32'h2);
		tdone();
		cfg(32'h102, 3, 2, 1);
		arm();
		repeat (40) @(posedge pclk);
		rd(cpg_pkg::OFS_STATUS, 32'h2);
		trig();
		run_pulse(3, 2);
		trig();
		repeat (40) @(posedge pclk);
		rd(cpg_pkg::OFS_STATUS, 32'h40);
		wr(cpg_pkg::OFS_CMD, 32'h2);
		tdone();
		seq(32'h103, 5, 3, 0, 2);
		wr(cpg_pkg::OFS_INCR, 32'h3);
		seq(32'h105, 2, 1, 3, 3);
		tdone();
		cfg(32'h144, 2, 3, 2);
		arm();
		repeat (40) @(posedge pclk);
		rd(cpg_pkg::OFS_STATUS, 32'h2);
		trig();
		run_pulse(2, 3);
		wait_out(1'b1, e);
		chk(32'(e - eb), 32'h2);
		wait_out(1'b0, x);
		wait_out(1'b1, b);
		chk(32'(b - e), 32'h5);
		@(posedge pclk);
		clk_en <= 1'b0;
		#1;
		chk(pready, 1'b0);
		repeat (20) @(posedge pclk);
		clk_en <= 1'b1;
		wr(cpg_pkg::OFS_CMD, 32'h2);
		tdone();
		cfg(32'h184, 1, 2, 2);
		@(posedge pclk);
		gate_in <= 1'b1;
		arm();
		repeat (60) @(posedge pclk);
		rd(cpg_pkg::OFS_STATUS, 32'h4);
		gate_in <= 1'b0;
		#1;
		base = nedge;
		wait_out(1'b1, e);
		chk(32'(e - base), 32'h1);
		wr(cpg_pkg::OFS_CMD, 32'h2);
		tdone();
		cfg(32'h201, 1, 1, 1);
		#1;
		chk(internal_out, 1'b1);
		arm();
		wait_out(1'b0, e);
		@(posedge pclk);
		#1;
		chk(internal_out, 1'b1);
		chk({terminal_count_flag, 31'(e - base)}, 32'h1);
		wr(cpg_pkg::OFS_CMD, 32'h2);
		tdone();
		cfg(32'h100, 1, 1, 1);
		arm();
		// second pass is a fresh interval on the next gate edge
		for (int i = 0; i < 2; i++) begin
			trig();
			repeat (30 + 11 * i) @(posedge pclk);
			aux_pulse();
			x = snap_a - snap_g;
			chk(dma_valid, 1'b1);
			chk(dma_data, 32'(x));
			aux_pulse();
			chk(dma_data, 32'(x));
			@(posedge pclk);
			dma_ready <= 1'b1;
			@(posedge pclk);
			dma_ready <= 1'b0;
			#1;
			chk(dma_valid, 1'b0);
		end
		wr(cpg_pkg::OFS_CMD, 32'h2);
		tdone();
		// divisors on fast then slow timebase
		for (int i = 0; i < 5; i++) begin
			x = dv[i];
			wr(cpg_pkg::OFS_FREQ, (i < 4) ? 32'(32 + x - 1) : 32'h30);
			b = (i < 4) ? 10 : 1000;
			repeat (2) begin
				wsq(1'b0, e);
				wsq(1'b1, e);
			end
			wsq(1'b0, e);
			chk(32'(e), 32'((x == 1) ? b : b * (x / 2)));
			wsq(1'b1, e);
			chk(32'(e), 32'((x == 1) ? b : b * ((x + 1) / 2)));
		end
		tdone();
		end_sim();
	end
endmodule
